// ===== rtl/aemhl_bank.sv
// Correctable error status/mask, advanced error cap/control and the 128-bit header log.
// Assumes one clock, synchronous resets, event inputs produced on CLK_SYS.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "aemhl_params.svh"

// What this block does
// - A 32-bit sticky read/write correctable mask register, reserved bits reading zero.
// - The advisory non-fatal mask bit 13 resets to one, giving a reset value 0x0000_2000.
// - Mask bits 12, 8, 7, 6 and 0 are writable and reset to zero.
// - Control bits 8 and 6 enable ECRC check and generation, sticky, reset to zero.
// - Bits 7 and 5 read as constant ones to report ECRC ability.
// - The first error index in bits 4:0 resets to zero and ignores software writes.
// - The captured header is kept in sticky read-only 32-bit words resetting to zero.
// - Header bits 127:96, 95:64, 63:32 appear at offsets 0x11C, 0x120, 0x124.
// - Header bits 31:0 appear at offset 0x128.
// - Correctable status bits share the mask positions, set on error, cleared by writing one.
module aemhl_bank (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic COLD_RST,
    input wire aemhl_pkg::aemhl_req_t BUS_REQ,
    output logic [31:0] RD_DATA,
    input wire logic [31:0] COR_EVENT,
    input wire aemhl_pkg::aemhl_capture_t UNCOR_CAPTURE,
    input wire logic UNCOR_LOGGED_SET,
    output logic [31:0] COR_REPORT,
    output logic ECRC_CHECK_ON,
    output logic ECRC_GEN_ON
);
    logic [31:0] correctable_error_mask;
    logic [31:0] correctable_error_status;
    logic ecrc_check_enable;
    logic ecrc_gen_enable;
    logic [4:0] first_error_index;
    logic [127:0] header_log;
    logic log_locked;
    logic wr_mask, wr_status, wr_ctrl;
    logic [31:0] next_rd;
    logic sticky_rst;

    // Sticky state sees only the cold reset; the ordinary reset leaves it alone
    // cold reset only
    assign sticky_rst = COLD_RST;

    assign wr_mask = BUS_REQ.wr && (BUS_REQ.addr == `AEMHL_OFF_COR_MASK);
    assign wr_status = BUS_REQ.wr && (BUS_REQ.addr == `AEMHL_OFF_COR_STATUS);
    assign wr_ctrl = BUS_REQ.wr && (BUS_REQ.addr == `AEMHL_OFF_CAP_CTRL);

    // Mask register: only defined positions are storage, the rest read zero
    // sticky mask
    always_ff @(posedge CLK_SYS) begin
        if (sticky_rst) begin
            correctable_error_mask <= `AEMHL_MASK_RESET;
        end else if (wr_mask) begin
            correctable_error_mask <= BUS_REQ.wdata & `AEMHL_MASK_WRITABLE;
        end
    end

    // Status: new events win over a write-one clear in the same cycle
    // set over clear
    always_ff @(posedge CLK_SYS) begin
        if (sticky_rst) begin
            correctable_error_status <= `AEMHL_ZERO32;
        end else if (wr_status) begin
            correctable_error_status <= ((correctable_error_status & ~BUS_REQ.wdata)
                | COR_EVENT) & `AEMHL_MASK_WRITABLE;
        end else begin
            correctable_error_status <= (correctable_error_status | COR_EVENT)
                & `AEMHL_MASK_WRITABLE;
        end
    end

    // ECRC enables, sticky read/write
    // ECRC enables
    always_ff @(posedge CLK_SYS) begin
        if (sticky_rst) begin
            ecrc_check_enable <= 1'b0;
            ecrc_gen_enable <= 1'b0;
        end else if (wr_ctrl) begin
            ecrc_check_enable <= BUS_REQ.wdata[`AEMHL_BIT_ECRC_CHECK_ENABLE];
            ecrc_gen_enable <= BUS_REQ.wdata[`AEMHL_BIT_ECRC_GEN_ENABLE];
        end
    end

    // Lock holds the first capture until its status bit is cleared upstream,
    // so a burst of errors cannot overwrite the log of the first one
    // first error capture
    always_ff @(posedge CLK_SYS) begin
        if (sticky_rst) begin
            first_error_index <= `AEMHL_ZERO5;
            header_log <= `AEMHL_ZERO128;
            log_locked <= 1'b0;
        end else if (UNCOR_CAPTURE.valid && !log_locked) begin
            first_error_index <= UNCOR_CAPTURE.index;
            header_log <= UNCOR_CAPTURE.header;
            log_locked <= 1'b1;
        end else if (log_locked && !UNCOR_LOGGED_SET) begin
            log_locked <= 1'b0;
        end
    end

    // Read decode; unmapped addresses read zero
    // read map
    always_comb begin
        next_rd = `AEMHL_ZERO32;
        if (BUS_REQ.addr == `AEMHL_OFF_COR_STATUS) begin
            next_rd = correctable_error_status;
        end else if (BUS_REQ.addr == `AEMHL_OFF_COR_MASK) begin
            next_rd = correctable_error_mask;
        end else if (BUS_REQ.addr == `AEMHL_OFF_CAP_CTRL) begin
            next_rd = `AEMHL_CAP_CTRL_RESET;
            next_rd[`AEMHL_BIT_ECRC_CHECK_ENABLE] = ecrc_check_enable;
            next_rd[`AEMHL_BIT_ECRC_GEN_ENABLE] = ecrc_gen_enable;
            next_rd[`AEMHL_PTR_MSB:0] = first_error_index;
        end else if (BUS_REQ.addr == `AEMHL_OFF_LOG1) begin
            next_rd = header_log[`AEMHL_LOG1_HI:`AEMHL_LOG1_LO];
        end else if (BUS_REQ.addr == `AEMHL_OFF_LOG2) begin
            next_rd = header_log[`AEMHL_LOG2_HI:`AEMHL_LOG2_LO];
        end else if (BUS_REQ.addr == `AEMHL_OFF_LOG3) begin
            next_rd = header_log[`AEMHL_LOG3_HI:`AEMHL_LOG3_LO];
        end else if (BUS_REQ.addr == `AEMHL_OFF_LOG4) begin
            next_rd = header_log[`AEMHL_LOG4_HI:`AEMHL_LOG4_LO];
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            RD_DATA <= `AEMHL_ZERO32;
        end else if (BUS_REQ.rd) begin
            RD_DATA <= next_rd;
        end else begin
            RD_DATA <= `AEMHL_ZERO32;
        end
    end

    // Unmasked correctable errors forwarded as pulses, registered
    // mask suppresses reporting
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            COR_REPORT <= `AEMHL_ZERO32;
            ECRC_CHECK_ON <= 1'b0;
            ECRC_GEN_ON <= 1'b0;
        end else begin
            COR_REPORT <= COR_EVENT & `AEMHL_MASK_WRITABLE & ~correctable_error_mask;
            ECRC_CHECK_ON <= ecrc_check_enable;
            ECRC_GEN_ON <= ecrc_gen_enable;
        end
    end

    property p_mask_reset;
        @(posedge CLK_SYS) $past(COLD_RST) |-> correctable_error_mask == `AEMHL_MASK_RESET;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask reset value wrong");

    property p_reserved_zero;
        @(posedge CLK_SYS) (correctable_error_mask & ~`AEMHL_MASK_WRITABLE) == `AEMHL_ZERO32;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved mask bit set");

    property p_mask_write;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            wr_mask |=> correctable_error_mask == ($past(BUS_REQ.wdata) & `AEMHL_MASK_WRITABLE);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost");

    property p_set_wins;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            COR_EVENT[`AEMHL_BIT_RXE] |=> correctable_error_status[`AEMHL_BIT_RXE];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("status event lost");

    property p_ctrl_read;
        @(posedge CLK_SYS) disable iff (SYS_RST || COLD_RST)
            (BUS_REQ.rd && BUS_REQ.addr == `AEMHL_OFF_CAP_CTRL) |=>
            RD_DATA[`AEMHL_BIT_ECRC_CHECK_CAPABLE] && RD_DATA[`AEMHL_BIT_ECRC_GEN_CAPABLE];
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("capability bits not one");

    property p_ptr_no_sw;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            (wr_ctrl && !UNCOR_CAPTURE.valid) |=> $stable(first_error_index);
    endproperty
    a_ptr_no_sw: assert property (p_ptr_no_sw) else $error("pointer changed by write");

    property p_capture;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            (UNCOR_CAPTURE.valid && !log_locked) |=>
            first_error_index == $past(UNCOR_CAPTURE.index) && log_locked;
    endproperty
    a_capture: assert property (p_capture) else $error("first error not captured");

    property p_hold;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            (log_locked && UNCOR_LOGGED_SET) |=> $stable(header_log);
    endproperty
    a_hold: assert property (p_hold) else $error("header log overwritten");

    property p_ecrc_en;
        @(posedge CLK_SYS) disable iff (COLD_RST || SYS_RST)
            wr_ctrl |=> ##1 ECRC_CHECK_ON == $past(BUS_REQ.wdata[`AEMHL_BIT_ECRC_CHECK_ENABLE], 2);
    endproperty
    a_ecrc_en: assert property (p_ecrc_en) else $error("check enable not applied");

    // generation enable applied
    // The generation enable reaches its output two edges after the write
    property p_gen_en;
        @(posedge CLK_SYS) disable iff (COLD_RST || SYS_RST)
            wr_ctrl |=> ##1 ECRC_GEN_ON == $past(BUS_REQ.wdata[`AEMHL_BIT_ECRC_GEN_ENABLE], 2);
    endproperty
    a_gen_en: assert property (p_gen_en) else $error("generation enable not applied");

    // idle read zero
    // Read data must not linger, so a bus with wired-or returns stays clean
    property p_rd_idle;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            !BUS_REQ.rd |=> RD_DATA == `AEMHL_ZERO32;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

    // first log word
    // Read data come from the log as it stood at the strobe edge
    property p_log1_read;
        @(posedge CLK_SYS) disable iff (SYS_RST || COLD_RST)
            (BUS_REQ.rd && BUS_REQ.addr == `AEMHL_OFF_LOG1) |=>
            RD_DATA == $past(header_log[`AEMHL_LOG1_HI:`AEMHL_LOG1_LO]);
    endproperty
    a_log1_read: assert property (p_log1_read) else $error("log word one wrong");

    // fourth log word
    // The lowest header word completes the captured header
    property p_log4_read;
        @(posedge CLK_SYS) disable iff (SYS_RST || COLD_RST)
            (BUS_REQ.rd && BUS_REQ.addr == `AEMHL_OFF_LOG4) |=>
            RD_DATA == $past(header_log[`AEMHL_LOG4_HI:`AEMHL_LOG4_LO]);
    endproperty
    a_log4_read: assert property (p_log4_read) else $error("log word four wrong");

    // status read
    // Software sees the status as it stood at the strobe edge
    property p_status_read;
        @(posedge CLK_SYS) disable iff (SYS_RST || COLD_RST)
            (BUS_REQ.rd && BUS_REQ.addr == `AEMHL_OFF_COR_STATUS) |=>
            RD_DATA == $past(correctable_error_status);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // write one clears
    // Clearing only applies when no new event on that bit arrives together
    property p_status_w1c;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            (wr_status && BUS_REQ.wdata[`AEMHL_BIT_RT] && !COR_EVENT[`AEMHL_BIT_RT]) |=>
            !correctable_error_status[`AEMHL_BIT_RT];
    endproperty
    a_status_w1c: assert property (p_status_w1c) else $error("status not cleared");

    // reserved status zero
    // Undefined event bits are dropped before they reach storage
    property p_status_reserved;
        @(posedge CLK_SYS)
            (correctable_error_status & ~`AEMHL_MASK_WRITABLE) == `AEMHL_ZERO32;
    endproperty
    a_status_reserved: assert property (p_status_reserved) else $error("status bit reserved");

    // masked reporting
    // Report uses the mask as it stood when the event arrived
    property p_report_mask;
        @(posedge CLK_SYS) disable iff (SYS_RST)
            1'b1 |=> COR_REPORT == ($past(COR_EVENT) & `AEMHL_MASK_WRITABLE
                & ~$past(correctable_error_mask));
    endproperty
    a_report_mask: assert property (p_report_mask) else $error("report ignores mask");

    // mask survives ordinary reset
    // An ordinary reset must not undo what software configured
    property p_mask_sticky;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            (SYS_RST && !wr_mask) |=> $stable(correctable_error_mask);
    endproperty
    a_mask_sticky: assert property (p_mask_sticky) else $error("mask lost on reset");

    // enables survive ordinary reset
    // Only the output copies drop during the ordinary reset
    property p_enable_sticky;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            (SYS_RST && !wr_ctrl) |=> $stable(ecrc_check_enable) && $stable(ecrc_gen_enable);
    endproperty
    a_enable_sticky: assert property (p_enable_sticky) else $error("enable lost on reset");

    // cold reset clears
    // Cold reset returns the status, first error index and header log to zero
    property p_cold_clear;
        @(posedge CLK_SYS)
            COLD_RST |=> correctable_error_status == `AEMHL_ZERO32
                && first_error_index == `AEMHL_ZERO5 && header_log == `AEMHL_ZERO128;
    endproperty
    a_cold_clear: assert property (p_cold_clear) else $error("cold reset left state");

    // lock releases
    // Release waits for the upstream status bit to drop, one edge late
    property p_lock_release;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            (log_locked && !UNCOR_LOGGED_SET) |=> !log_locked;
    endproperty
    a_lock_release: assert property (p_lock_release) else $error("log lock stuck");

    // index held
    // A later error must not move the index of the logged one
    property p_index_hold;
        @(posedge CLK_SYS) disable iff (COLD_RST)
            (log_locked && UNCOR_LOGGED_SET) |=> $stable(first_error_index);
    endproperty
    a_index_hold: assert property (p_index_hold) else $error("error index overwritten");
endmodule

// ===== rtl/aemhl_params.svh
// Register offsets, field positions, reset values for the error mask / header log bank.
// Assumes inclusion by bare name from the package and the top module.
`ifndef AEMHL_PARAMS_SVH
`define AEMHL_PARAMS_SVH
`define AEMHL_OFF_COR_STATUS 12'h110
`define AEMHL_OFF_COR_MASK 12'h114
`define AEMHL_OFF_CAP_CTRL 12'h118
`define AEMHL_OFF_LOG1 12'h11C
`define AEMHL_OFF_LOG2 12'h120
`define AEMHL_OFF_LOG3 12'h124
`define AEMHL_OFF_LOG4 12'h128
`define AEMHL_MASK_RESET 32'h0000_2000
`define AEMHL_MASK_WRITABLE 32'h0000_31C1
`define AEMHL_CAP_CTRL_RESET 32'h0000_00A0
`define AEMHL_BIT_ANF 13
`define AEMHL_BIT_RT 12
`define AEMHL_BIT_RN 8
`define AEMHL_BIT_BDLLP 7
`define AEMHL_BIT_BTLP 6
`define AEMHL_BIT_RXE 0
`define AEMHL_BIT_ECRC_CHECK_ENABLE 8
`define AEMHL_BIT_ECRC_CHECK_CAPABLE 7
`define AEMHL_BIT_ECRC_GEN_ENABLE 6
`define AEMHL_BIT_ECRC_GEN_CAPABLE 5
`define AEMHL_PTR_MSB 4
`define AEMHL_LOG1_HI 127
`define AEMHL_LOG1_LO 96
`define AEMHL_LOG2_HI 95
`define AEMHL_LOG2_LO 64
`define AEMHL_LOG3_HI 63
`define AEMHL_LOG3_LO 32
`define AEMHL_LOG4_HI 31
`define AEMHL_LOG4_LO 0
`define AEMHL_ZERO32 32'h0000_0000
`define AEMHL_ZERO128 128'h0
`define AEMHL_ZERO5 5'h00
`endif

// ===== rtl/aemhl_pkg.sv
// Types shared by the error mask / header log bank.
// Assumes aemhl_params.svh is on the include path.
`include "aemhl_params.svh"
package aemhl_pkg;
    // Capture event from the uncorrectable error logic
    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic [127:0] header;
    } aemhl_capture_t;
    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } aemhl_req_t;
endpackage

// ===== verification/aemhl_bank_tb.sv
// Self-checking bench for the error mask / header log bank.
// Assumes the rtl/ package and bank are compiled first; no checker of its own.
`timescale 1ns/1ps
`include "aemhl_params.svh"
module aemhl_bank_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cold_rst = 1'b1;
    aemhl_pkg::aemhl_req_t bus_req = '0;
    aemhl_pkg::aemhl_capture_t uncor_capture = '0;
    logic [31:0] cor_event = 32'h0000_0000;
    logic uncor_logged_set = 1'b0;
    logic [31:0] rd_data;
    logic [31:0] cor_report;
    logic ecrc_check_on;
    logic ecrc_gen_on;
    int num_errors = 0;
    int total_checks = 0;
    localparam logic [127:0] HDR_A = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    localparam logic [127:0] HDR_B = 128'hFEED_0001_CAFE_0002_BEEF_0003_D00D_0004;

    aemhl_bank i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .COLD_RST(cold_rst),
        .BUS_REQ(bus_req), .RD_DATA(rd_data), .COR_EVENT(cor_event),
        .UNCOR_CAPTURE(uncor_capture), .UNCOR_LOGGED_SET(uncor_logged_set),
        .COR_REPORT(cor_report), .ECRC_CHECK_ON(ecrc_check_on), .ECRC_GEN_ON(ecrc_gen_on));

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One strobe cycle; the next call always lets an edge pass first
    task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, 1'b1, a, 32'h0000_0000);
        #1;
        check(rd_data, exp);
    endtask

    task automatic logs(input logic [127:0] h);
        for (int i = 0; i < 4; i++) begin
            rd(12'h11C + 12'(4 * i), h[127 - 32 * i -: 32]);
        end
    endtask

    task automatic cor_pulse(input logic [31:0] exp);
        @(posedge clk_sys);
        cor_event <= 32'hFFFF_FFFF;
        @(posedge clk_sys);
        cor_event <= 32'h0000_0000;
        #1;
        check(cor_report, exp);
    endtask

    task automatic capture(input logic [4:0] idx, input logic [127:0] h);
        @(posedge clk_sys);
        uncor_capture <= '{valid: 1'b1, index: idx, header: h};
        uncor_logged_set <= 1'b1;
        @(posedge clk_sys);
        uncor_capture.valid <= 1'b0;
    endtask

    // One-cycle pulse on either reset input
    task automatic pulse_reset(input logic cold);
        @(posedge clk_sys);
        if (cold) cold_rst <= 1'b1;
        else sys_rst <= 1'b1;
        @(posedge clk_sys);
        cold_rst <= 1'b0;
        sys_rst <= 1'b0;
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs well under 300 cycles
    initial begin
        repeat (2000) @(posedge clk_sys);
        num_errors++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        cold_rst <= 1'b0;
        rd(`AEMHL_OFF_COR_MASK, 32'h0000_2000);
        rd(`AEMHL_OFF_CAP_CTRL, 32'h0000_00A0);
        logs(128'h0);
        rd(12'h200, 32'h0000_0000);
        wr(`AEMHL_OFF_COR_MASK, 32'hFFFF_FFFF);
        rd(`AEMHL_OFF_COR_MASK, 32'h0000_31C1);
        wr(`AEMHL_OFF_COR_MASK, 32'h0000_0000);
        rd(`AEMHL_OFF_COR_MASK, 32'h0000_0000);
        cor_pulse(32'h0000_31C1);
        rd(`AEMHL_OFF_COR_STATUS, 32'h0000_31C1);
        wr(`AEMHL_OFF_COR_STATUS, 32'h0000_0041);
        rd(`AEMHL_OFF_COR_STATUS, 32'h0000_3180);
        wr(`AEMHL_OFF_COR_MASK, 32'h0000_1100);
        cor_pulse(32'h0000_20C1);
        wr(`AEMHL_OFF_CAP_CTRL, 32'hFFFF_FFFF);
        rd(`AEMHL_OFF_CAP_CTRL, 32'h0000_01E0);
        check({31'h0, ecrc_check_on}, 32'h0000_0001);
        check({31'h0, ecrc_gen_on}, 32'h0000_0001);
        capture(5'h15, HDR_A);
        rd(`AEMHL_OFF_CAP_CTRL, 32'h0000_01F5);
        logs(HDR_A);
        wr(`AEMHL_OFF_LOG1, 32'h0000_0000);
        rd(`AEMHL_OFF_LOG1, 32'h0123_4567);
        // A second error while the first stays logged must not overwrite
        capture(5'h03, HDR_B);
        rd(`AEMHL_OFF_CAP_CTRL, 32'h0000_01F5);
        logs(HDR_A);
        @(posedge clk_sys);
        uncor_logged_set <= 1'b0;
        repeat (2) @(posedge clk_sys);
        capture(5'h03, HDR_B);
        rd(`AEMHL_OFF_CAP_CTRL, 32'h0000_01E3);
        logs(HDR_B);
        pulse_reset(1'b0);
        rd(`AEMHL_OFF_COR_MASK, 32'h0000_1100);
        rd(`AEMHL_OFF_COR_STATUS, 32'h0000_31C1);
        rd(`AEMHL_OFF_CAP_CTRL, 32'h0000_01E3);
        logs(HDR_B);
        check({31'h0, ecrc_check_on}, 32'h0000_0001);
        check({31'h0, ecrc_gen_on}, 32'h0000_0001);
        pulse_reset(1'b1);
        rd(`AEMHL_OFF_COR_MASK, 32'h0000_2000);
        rd(`AEMHL_OFF_COR_STATUS, 32'h0000_0000);
        rd(`AEMHL_OFF_CAP_CTRL, 32'h0000_00A0);
        logs(128'h0);
        check({31'h0, ecrc_check_on}, 32'h0000_0000);
        check({31'h0, ecrc_gen_on}, 32'h0000_0000);
        final_report();
    end
endmodule
